// >>> rtl/pps_pkg.sv
// Constants, instruction word layout and state types for the pulse pattern sequencer.
// Assumes one 100 MHz core clock and a host that loads program words through plain ports.
package pps_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_W = 80;
  localparam int PAT_LSB = 0;
  localparam int PAT_W = 21;
  localparam int SP_LSB = 21;
  localparam int SP_W = 3;
  localparam int OP_LSB = 24;
  localparam int OP_W = 4;
  localparam int DATA_LSB = 28;
  localparam int DATA_W = 20;
  localparam int DLY_LSB = 48;
  localparam int DLY_W = 32;
  localparam int DUR_W = DATA_W + DLY_W;
  localparam int LCNT_W = 20;
  localparam int ADDR_W_STD = 12;
  localparam int ADDR_W_LARGE = 15;
  localparam int MIN_CYC_STD = 6;
  localparam int MIN_CYC_EXT = 7;
  localparam int STACK_DEPTH = 8;
  localparam int TRIG_LAT_CYC = 8;
  localparam int LAT_W = 4;
  localparam int FETCH_AT = 2;
  localparam int RETRIG_MAX_MHZ = 15;
  localparam logic SP_OFF_LOW = 1'b0;

  typedef enum logic [OP_W-1:0] {
    OP_CONT, OP_STOP, OP_LOOP, OP_ENDL, OP_JSR, OP_RTS, OP_BR, OP_LONG, OP_WAIT
  } op_t;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT, S_LAT} state_t;
endpackage

// >>> rtl/pulse_pattern_sequencer.sv
// Microprogrammed pulse and pattern sequencer: program memory, flow control,
// per-instruction duration counter, short-pulse cut-off and trigger wait.
// Assumes host, trigger and stop inputs are synchronous to core_clk_i.
`timescale 1ns/1ns
module pulse_pattern_sequencer #(
  parameter int ADDR_W = pps_pkg::ADDR_W_STD,
  parameter int MIN_CYC = pps_pkg::MIN_CYC_STD,
  parameter int STK_D = pps_pkg::STACK_DEPTH,
  parameter logic SP_OFF_LVL = pps_pkg::SP_OFF_LOW
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // host_bus_interface program load and control
  input wire logic prog_we_i,
  input wire logic [ADDR_W-1:0] prog_addr_i,
  input wire logic [pps_pkg::WORD_W-1:0] prog_data_i,
  input wire logic start_i,
  input wire logic stop_i,
  // external lines
  input wire logic ext_trig_i,
  input wire logic ext_stop_i,
  // pattern and status
  output logic [pps_pkg::PAT_W-1:0] pattern_o,
  output logic running_o,
  output logic waiting_o
);
  import pps_pkg::*;

  localparam int SPTR_W = $clog2(STK_D + 1);
  localparam int IDX_W = $clog2(STK_D);
  localparam logic [SPTR_W-1:0] STK_FULL = SPTR_W'(STK_D);
  localparam logic [SPTR_W-1:0] ONE_P = SPTR_W'(1);
  localparam logic [DUR_W-1:0] FETCH_CNT = DUR_W'(FETCH_AT);
  localparam logic [LAT_W-1:0] LAT_LOAD = LAT_W'(TRIG_LAT_CYC - 1);

  function automatic op_t op_of(input logic [WORD_W-1:0] w);
    return op_t'(w[OP_LSB +: OP_W]);
  endfunction

  function automatic logic [DATA_W-1:0] data_of(input logic [WORD_W-1:0] w);
    return w[DATA_LSB +: DATA_W];
  endfunction

  // programmed length, stretched to the variant's minimum
  function automatic logic [DUR_W-1:0] dur_of(input logic [WORD_W-1:0] w);
    logic [DUR_W-1:0] raw;
    raw = DUR_W'(w[DLY_LSB +: DLY_W]);
    if (op_of(w) == OP_LONG) begin
      raw = {data_of(w), w[DLY_LSB +: DLY_W]};
    end
    if (raw < DUR_W'(MIN_CYC)) begin
      raw = DUR_W'(MIN_CYC);
    end
    return raw;
  endfunction

  // short-pulse length; zero means the field is at its off code
  function automatic logic [SP_W-1:0] sp_len(input logic [WORD_W-1:0] w);
    return w[SP_LSB +: SP_W] ^ {SP_W{SP_OFF_LVL}};
  endfunction

  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] mem_q_ff;
  logic [WORD_W-1:0] ins_ff;
  logic [ADDR_W-1:0] pc_ff;
  logic [ADDR_W-1:0] fetch_ff;
  logic [DUR_W-1:0] dur_ff;
  logic [LAT_W-1:0] lat_ff;
  logic [SP_W-1:0] sp_ff;
  logic [PAT_W-1:0] out_ff;
  logic run_ff;
  logic wait_ff;
  logic trig_d_ff;
  state_t state_ff;
  state_t nxt_state;
  logic [LCNT_W-1:0] lstk [0:STK_D-1];
  logic [ADDR_W-1:0] cstk [0:STK_D-1];
  logic [SPTR_W-1:0] lsp_ff;
  logic [SPTR_W-1:0] csp_ff;
  logic [ADDR_W-1:0] nxt_pc;
  logic [LCNT_W-1:0] ltop;
  logic [ADDR_W-1:0] ctop;
  logic [ADDR_W-1:0] data_addr;
  logic [WORD_W-1:0] ld_word;
  logic halt;
  logic trig_rise;
  logic boundary;
  logic take;
  logic go_wait;
  logic resume;
  logic ld;
  logic step;

  assign halt = stop_i | ext_stop_i;
  assign trig_rise = ext_trig_i & ~trig_d_ff;
  assign boundary = (state_ff == S_RUN) && (dur_ff == '0);
  // a start from idle behaves like the end of an instruction
  assign take = (boundary && op_of(ins_ff) != OP_STOP) ||
                (state_ff == S_IDLE && (start_i || trig_rise));
  assign go_wait = take && op_of(mem_q_ff) == OP_WAIT;
  assign resume = (state_ff == S_LAT) && (lat_ff == '0);
  assign ld = (take && !go_wait) || resume;
  assign ld_word = resume ? ins_ff : mem_q_ff;
  assign step = (state_ff == S_RUN) && (dur_ff == FETCH_CNT);
  assign ltop = (lsp_ff == '0) ? '0 : lstk[IDX_W'(lsp_ff - ONE_P)];
  assign ctop = (csp_ff == '0) ? '0 : cstk[IDX_W'(csp_ff - ONE_P)];
  assign data_addr = ADDR_W'(data_of(ins_ff));

  assign pattern_o = out_ff;
  assign running_o = run_ff;
  assign waiting_o = wait_ff;

  // host writes program words at any time; a start right after a write to
  // word zero sees the old word for one cycle
  always_ff @(posedge core_clk_i) begin
    if (prog_we_i) begin
      mem[prog_addr_i] <= prog_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    mem_q_ff <= mem[fetch_ff];
  end

  always_comb begin
    nxt_pc = pc_ff + 1'b1;
    case (op_of(ins_ff))
      OP_BR, OP_JSR: begin
        nxt_pc = data_addr;
      end
      OP_RTS: begin
        if (csp_ff != '0) begin
          nxt_pc = ctop;
        end
      end
      OP_ENDL: begin
        if (ltop != '0) begin
          nxt_pc = data_addr;
        end
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (take) begin
          nxt_state = go_wait ? S_WAIT : S_RUN;
        end
      end
      S_RUN: begin
        if (boundary && op_of(ins_ff) == OP_STOP) begin
          nxt_state = S_IDLE;
        end else if (go_wait) begin
          nxt_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (trig_rise) begin
          nxt_state = S_LAT;
        end
      end
      S_LAT: begin
        if (lat_ff == '0) begin
          nxt_state = S_RUN;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    if (halt) begin
      nxt_state = S_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
      run_ff <= 1'b0;
      wait_ff <= 1'b0;
      trig_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      run_ff <= nxt_state != S_IDLE;
      wait_ff <= nxt_state == S_WAIT;
      trig_d_ff <= ext_trig_i;
    end
  end

  // trigger-to-output latency
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_ff <= '0;
    end else if (state_ff == S_WAIT && trig_rise) begin
      lat_ff <= LAT_LOAD;
    end else if (state_ff == S_LAT && lat_ff != '0) begin
      lat_ff <= lat_ff - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ins_ff <= '0;
      pc_ff <= '0;
      fetch_ff <= '0;
    end else begin
      if (take) begin
        ins_ff <= mem_q_ff;
        pc_ff <= fetch_ff;
      end
      // idle parks the fetch address on word zero for the next start
      if (halt || (boundary && op_of(ins_ff) == OP_STOP)) begin
        fetch_ff <= '0;
      end else if (step) begin
        fetch_ff <= nxt_pc;
      end
    end
  end

  // duration counter, one count per clock for every length
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dur_ff <= '0;
    end else if (halt) begin
      dur_ff <= '0;
    end else if (ld) begin
      dur_ff <= dur_of(ld_word) - 1'b1;
    end else if (state_ff == S_RUN && dur_ff != '0) begin
      dur_ff <= dur_ff - 1'b1;
    end
  end

  // whole pattern loads at once; a short-pulse expiry or a halt clears it early
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= '0;
      sp_ff <= '0;
    end else if (halt) begin
      out_ff <= '0;
      sp_ff <= '0;
    end else if (ld) begin
      out_ff <= ld_word[PAT_LSB +: PAT_W];
      sp_ff <= sp_len(ld_word);
    end else if (sp_ff != '0) begin
      sp_ff <= sp_ff - 1'b1;
      if (sp_ff == SP_W'(1)) begin
        out_ff <= '0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lsp_ff <= '0;
      csp_ff <= '0;
    end else if (halt) begin
      lsp_ff <= '0;
      csp_ff <= '0;
    end else if (step) begin
      case (op_of(ins_ff))
        OP_LOOP: begin
          if (lsp_ff != STK_FULL) begin
            lsp_ff <= lsp_ff + 1'b1;
          end
        end
        OP_ENDL: begin
          if (lsp_ff != '0 && ltop == '0) begin
            lsp_ff <= lsp_ff - 1'b1;
          end
        end
        OP_JSR: begin
          if (csp_ff != STK_FULL) begin
            csp_ff <= csp_ff + 1'b1;
          end
        end
        OP_RTS: begin
          if (csp_ff != '0) begin
            csp_ff <= csp_ff - 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // loop entries hold passes left; a count of zero wraps to 1,048,576 passes
  always_ff @(posedge core_clk_i) begin
    if (step && !halt) begin
      if (op_of(ins_ff) == OP_LOOP && lsp_ff != STK_FULL) begin
        lstk[IDX_W'(lsp_ff)] <= LCNT_W'(data_of(ins_ff)) - 1'b1;
      end
      if (op_of(ins_ff) == OP_ENDL && lsp_ff != '0 && ltop != '0) begin
        lstk[IDX_W'(lsp_ff - ONE_P)] <= ltop - 1'b1;
      end
      if (op_of(ins_ff) == OP_JSR && csp_ff != STK_FULL) begin
        cstk[IDX_W'(csp_ff)] <= pc_ff + 1'b1;
      end
    end
  end

  // cycles since the last pattern load, and the length that load asked for
  logic [DUR_W-1:0] cyc_ff;
  logic [DUR_W-1:0] dreq_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_ff <= '0;
      dreq_ff <= '0;
    end else if (ld) begin
      cyc_ff <= '0;
      dreq_ff <= dur_of(ld_word);
    end else begin
      cyc_ff <= cyc_ff + 1'b1;
    end
  end

  property p_min_dur;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    (state_ff == S_RUN && ld) |-> (cyc_ff >= DUR_W'(MIN_CYC - 1));
  endproperty
  a_min_dur: assert property (p_min_dur)
    else $error("instruction shorter than the minimum");

  property p_exact_dur;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    (state_ff == S_RUN && ld) |-> (cyc_ff + 1'b1 == dreq_ff);
  endproperty
  a_exact_dur: assert property (p_exact_dur)
    else $error("instruction length differs from its programmed count");

  property p_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    (state_ff == S_RUN && dur_ff > FETCH_CNT && sp_ff == '0) |=> $stable(pattern_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pattern moved inside an instruction");

  property p_short;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    (ld && sp_len(ld_word) == SP_W'(1)) |=> ##1 (pattern_o == '0);
  endproperty
  a_short: assert property (p_short)
    else $error("one-cycle short pulse not cut back");

  property p_pattern;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    ld |=> (pattern_o == $past(ld_word[PAT_LSB +: PAT_W]));
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("pattern does not match the loaded word");

  property p_trig_lat;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    (state_ff == S_WAIT && trig_rise) |=> (state_ff == S_LAT) [*8] ##1 (state_ff == S_RUN);
  endproperty
  a_trig_lat: assert property (p_trig_lat)
    else $error("trigger latency is not eight cycles");

  property p_stack;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (lsp_ff <= STK_FULL) && (csp_ff <= STK_FULL);
  endproperty
  a_stack: assert property (p_stack)
    else $error("stack pointer past eight levels");

  property p_loop_load;
    @(posedge core_clk_i) disable iff (!rst_n_i || halt)
    (step && op_of(ins_ff) == OP_LOOP && lsp_ff != STK_FULL)
      |=> (ltop == $past(data_of(ins_ff)) - 1'b1);
  endproperty
  a_loop_load: assert property (p_loop_load)
    else $error("loop counter not loaded from the count field");

  property p_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (state_ff == S_IDLE && trig_rise && !halt) |=> running_o;
  endproperty
  a_start: assert property (p_start)
    else $error("trigger did not start execution");

  property p_stop;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    halt |=> (!running_o && pattern_o == '0);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not reset the sequencer");
endmodule

// >>> sim/host_loader_model.sv
// Host side model: loads program words and issues start and stop requests.
// Assumes the sequencer samples its inputs on the rising edge of core_clk_i.
`timescale 1ns/1ns
module host_loader_model #(
  parameter int ADDR_W = pps_pkg::ADDR_W_STD
) (
  // clock
  input wire logic core_clk_i,
  // program load and control
  output logic prog_we_o,
  output logic [ADDR_W-1:0] prog_addr_o,
  output logic [pps_pkg::WORD_W-1:0] prog_data_o,
  output logic start_o,
  output logic stop_o
);
  import pps_pkg::*;

  initial begin
    prog_we_o = 1'b0;
    prog_addr_o = '0;
    prog_data_o = '0;
    start_o = 1'b0;
    stop_o = 1'b0;
  end

  // one word per strobe, bus shows the inverse once released
  task automatic write_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(negedge core_clk_i);
    prog_we_o = 1'b1;
    prog_addr_o = a;
    prog_data_o = d;
    @(negedge core_clk_i);
    prog_we_o = 1'b0;
    prog_addr_o = ~a;
    prog_data_o = ~d;
  endtask

  task automatic pulse_start();
    @(negedge core_clk_i);
    start_o = 1'b1;
    @(negedge core_clk_i);
    start_o = 1'b0;
  endtask

  // called at a falling edge, takes effect at the next rising edge
  task automatic set_stop(input logic v);
    stop_o = v;
  endtask
endmodule

// >>> sim/test_pulse_pattern_sequencer.sv
// Self-checking bench for the pulse pattern sequencer with a host model.
// Assumes default parameters: 4096 words, six-cycle minimum, code 0 is off.
`timescale 1ns/1ns
module test_pulse_pattern_sequencer;
  import pps_pkg::*;
  logic core_clk_i;
  logic rst_n_i;
  logic prog_we;
  logic start;
  logic stop;
  logic ext_trig_i;
  logic ext_stop_i;
  logic [ADDR_W_STD-1:0] prog_addr;
  logic [WORD_W-1:0] prog_data;
  logic [PAT_W-1:0] pattern_o;
  logic running_o;
  logic waiting_o;
  int errors;
  int n_compared;

  host_loader_model i_host (.core_clk_i(core_clk_i), .prog_we_o(prog_we),
    .prog_addr_o(prog_addr), .prog_data_o(prog_data), .start_o(start), .stop_o(stop));

  pulse_pattern_sequencer i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .prog_we_i(prog_we), .prog_addr_i(prog_addr), .prog_data_i(prog_data),
    .start_i(start), .stop_i(stop), .ext_trig_i(ext_trig_i), .ext_stop_i(ext_stop_i),
    .pattern_o(pattern_o), .running_o(running_o), .waiting_o(waiting_o));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  function automatic logic [WORD_W-1:0] mk(input logic [PAT_W-1:0] p,
      input logic [SP_W-1:0] s, input op_t op, input logic [DATA_W-1:0] d,
      input logic [DLY_W-1:0] l);
    return {l, d, op, s, p};
  endfunction

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [PAT_W-1:0] e, input logic [PAT_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  // one sample per cycle from the current falling edge on; returns n falling edges later
  task automatic seg(input logic [PAT_W-1:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      chk("pattern_o", p, pattern_o);
      @(negedge core_clk_i);
    end
  endtask

  task automatic wait_idle();
    int k = 0;
    while (running_o !== 1'b0 && k < 100) begin
      @(negedge core_clk_i);
      k++;
    end
    if (k == 100) begin
      errors++;
      $display("MISMATCH running_o expected 0 seen %b", running_o);
      results();
    end
  endtask

  task automatic t_basic();
    i_host.write_word(0, mk(21'h15A5A5, 0, OP_CONT, 0, 7));
    i_host.write_word(1, mk(21'h0A5A5A, 0, OP_STOP, 0, 9));
    i_host.pulse_start();
    seg(21'h15A5A5, 7);
    chk("running_o", 1, PAT_W'(running_o));
    seg(21'h0A5A5A, 10);
    chk("running_o", 0, PAT_W'(running_o));
    $display("test basic done");
  endtask

  task automatic t_short();
    i_host.write_word(0, mk(21'h1FFFFF, 3'h1, OP_CONT, 0, 2));
    i_host.write_word(1, mk(21'h123456, 0, OP_LONG, 0, 8));
    i_host.write_word(2, mk(21'h0EDCBA, 0, OP_STOP, 0, 6));
    i_host.pulse_start();
    seg(21'h1FFFFF, 1);
    seg(0, 5);
    seg(21'h123456, 8);
    seg(21'h0EDCBA, 6);
    wait_idle();
    $display("test short done");
  endtask

  task automatic t_loop();
    logic [PAT_W-1:0] ex [8] = '{1, 2, 16, 4, 2, 16, 4, 8};
    i_host.write_word(0, mk(21'h000001, 0, OP_LOOP, 2, 6));
    i_host.write_word(1, mk(21'h000002, 0, OP_JSR, 5, 6));
    i_host.write_word(2, mk(21'h000004, 0, OP_ENDL, 1, 6));
    i_host.write_word(3, mk(21'h000008, 0, OP_STOP, 0, 6));
    i_host.write_word(5, mk(21'h000010, 0, OP_RTS, 0, 6));
    i_host.pulse_start();
    foreach (ex[i]) seg(ex[i], 6);
    wait_idle();
    $display("test loop done");
  endtask

  // a branch skips the words between it and its target
  task automatic t_branch();
    i_host.write_word(0, mk(21'h000111, 0, OP_BR, 3, 6));
    i_host.write_word(3, mk(21'h000222, 0, OP_STOP, 0, 6));
    i_host.pulse_start();
    seg(21'h000111, 6);
    seg(21'h000222, 6);
    wait_idle();
    $display("test branch done");
  endtask

  task automatic t_wait();
    i_host.write_word(0, mk(21'h00F00F, 0, OP_CONT, 0, 6));
    i_host.write_word(1, mk(21'h1F0000, 0, OP_WAIT, 0, 6));
    i_host.write_word(2, mk(21'h00003C, 0, OP_STOP, 0, 6));
    i_host.pulse_start();
    seg(21'h00F00F, 9);
    chk("waiting_o", 1, PAT_W'(waiting_o));
    ext_trig_i = 1'b1;
    @(negedge core_clk_i);
    seg(21'h00F00F, 8);
    seg(21'h1F0000, 6);
    seg(21'h00003C, 6);
    wait_idle();
    ext_trig_i = 1'b0;
    $display("test wait done");
  endtask

  task automatic t_stop();
    i_host.write_word(0, mk(21'h0F0F0F, 0, OP_STOP, 0, 1000));
    i_host.pulse_start();
    seg(21'h0F0F0F, 3);
    ext_stop_i = 1'b1;
    @(negedge core_clk_i);
    seg(0, 2);
    chk("running_o", 0, PAT_W'(running_o));
    ext_stop_i = 1'b0;
    ext_trig_i = 1'b1;
    @(negedge core_clk_i);
    seg(21'h0F0F0F, 2);
    i_host.set_stop(1'b1);
    @(negedge core_clk_i);
    seg(0, 2);
    chk("running_o", 0, PAT_W'(running_o));
    i_host.set_stop(1'b0);
    ext_trig_i = 1'b0;
    $display("test stop done");
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    ext_trig_i = 1'b0;
    ext_stop_i = 1'b0;
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk("pattern_o", 0, pattern_o);
    t_basic();
    t_short();
    t_loop();
    t_branch();
    t_wait();
    t_stop();
    results();
  end
endmodule
